// File: design/lane_cfg_pkg.sv
// constants, types and behaviour list for the lane configuration slice
// Behaviour
// - rx-detect code 00 keeps input high impedance; code 11 fixes 50 ohm termination
// - code 01 probes every 12 ms, at most 50 times, then stops
// - code 10 probes every 12 ms without limit until a load appears
// - rx-detect register field acts only while control bit 0x08[3] overrides strap
// - assert threshold bits 3:2 select 50, 40, 75 or 58 mVp-p
// - deassert threshold bits 1:0 select 37, 22, 55 or 45 mVp-p
// - threshold fields replace the strap only while control bit 0x08[6] is set
// - 8-bit equalizer register per lane, reset value 0x2F
// - output swing bit 7 enables short-circuit protection when one
// - swing code 000 to 111 maps to ratios 0.57 up to 1.04
package lane_cfg_pkg;
	localparam logic [7:0] OFF_THRESH = 8'h2F;
	localparam logic [7:0] OFF_RSV_A  = 8'h30;
	localparam logic [7:0] OFF_RSV_B  = 8'h31;
	localparam logic [7:0] OFF_DETECT = 8'h32;
	localparam logic [7:0] OFF_EQ     = 8'h33;
	localparam logic [7:0] OFF_SWING  = 8'h34;

	localparam logic [3:0] RST_THRESH = 4'h0;
	localparam logic [1:0] RST_DETECT = 2'h0;
	localparam logic [7:0] RST_EQ     = 8'h2F;
	localparam logic [7:0] RST_SWING  = 8'hAD;
	localparam logic [7:0] RD_ZERO    = 8'h00;

	localparam int DETECT_LSB = 2;
	localparam int SD_AS_LSB  = 2;
	localparam int SD_DE_LSB  = 0;
	localparam int SCP_BIT    = 7;
	localparam int SWING_LSB  = 0;

	localparam int CLK_HZ           = 50_000_000;
	localparam int PROBE_PERIOD_MS  = 12;
	localparam int PROBE_PERIOD_CYC = PROBE_PERIOD_MS * (CLK_HZ / 1000);
	localparam int MAX_ATTEMPTS     = 50;

	typedef enum logic [1:0] {
		MODE_HIZ       = 2'h0,
		MODE_LIMITED   = 2'h1,
		MODE_UNLIMITED = 2'h2,
		MODE_FIXED     = 2'h3
	} detect_mode_type;

	typedef enum logic [6:0] {
		ST_START = 7'h01,
		ST_HIZ   = 7'h02,
		ST_TERM  = 7'h04,
		ST_WAIT  = 7'h08,
		ST_PROBE = 7'h10,
		ST_FOUND = 7'h20,
		ST_STOP  = 7'h40
	} det_state_type;
endpackage

// File: design/rx_detect_seq.sv
// receiver-detect probe sequencer for one lane
`timescale 1ns/100ps
module rx_detect_seq #(
	parameter int PERIOD_CYC = lane_cfg_pkg::PROBE_PERIOD_CYC,
	parameter int ATTEMPTS   = lane_cfg_pkg::MAX_ATTEMPTS,
	parameter int CNT_W      = 20
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic [1:0] i_mode,
	input  wire logic       i_load_seen,
	output logic            o_probe_q,
	output logic            o_term_50_q
);
	localparam logic [CNT_W-1:0] LAST     = CNT_W'(PERIOD_CYC - 1);
	localparam logic [6:0]       LAST_TRY = 7'(ATTEMPTS - 1);

	lane_cfg_pkg::det_state_type state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [6:0]       tries_q, tries_d;
	logic [1:0]       mode_q;
	logic             probe_d, term_d;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		tries_d = tries_q;
		if (i_mode != mode_q) begin
			state_d = lane_cfg_pkg::ST_START;
			cnt_d   = '0;
			tries_d = '0;
		end else begin
			case (state_q)
				lane_cfg_pkg::ST_START: begin
					if (i_mode == lane_cfg_pkg::MODE_HIZ) begin
						state_d = lane_cfg_pkg::ST_HIZ;
					end else if (i_mode == lane_cfg_pkg::MODE_FIXED) begin
						state_d = lane_cfg_pkg::ST_TERM;
					end else begin
						state_d = lane_cfg_pkg::ST_WAIT;
					end
				end
				lane_cfg_pkg::ST_WAIT: begin
					if (cnt_q == LAST) begin
						cnt_d   = '0;
						state_d = lane_cfg_pkg::ST_PROBE;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				lane_cfg_pkg::ST_PROBE: begin
					if (i_load_seen) begin
						state_d = lane_cfg_pkg::ST_FOUND;
					end else if (i_mode == lane_cfg_pkg::MODE_LIMITED && tries_q == LAST_TRY) begin
						state_d = lane_cfg_pkg::ST_STOP;
					end else begin
						state_d = lane_cfg_pkg::ST_WAIT;
						if (i_mode == lane_cfg_pkg::MODE_LIMITED) begin
							tries_d = tries_q + 1'b1;
						end
					end
				end
				default: state_d = state_q;
			endcase
		end
		probe_d = (state_d == lane_cfg_pkg::ST_PROBE);
		term_d  = (state_d == lane_cfg_pkg::ST_TERM) || (state_d == lane_cfg_pkg::ST_FOUND);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q     <= lane_cfg_pkg::ST_START;
			cnt_q       <= '0;
			tries_q     <= '0;
			mode_q      <= lane_cfg_pkg::MODE_HIZ;
			o_probe_q   <= 1'b0;
			o_term_50_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			cnt_q       <= cnt_d;
			tries_q     <= tries_d;
			mode_q      <= i_mode;
			o_probe_q   <= probe_d;
			o_term_50_q <= term_d;
		end
	end

	// probe counter since last mode change, for checking only
	int pcount_q;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pcount_q <= 0;
		end else if (i_mode != mode_q) begin
			pcount_q <= 0;
		end else if (o_probe_q) begin
			pcount_q <= pcount_q + 1;
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence probe_due;
		state_q == lane_cfg_pkg::ST_WAIT && cnt_q == LAST && i_mode == mode_q;
	endsequence
	sequence probe_hit;
		o_probe_q && i_load_seen && i_mode == mode_q;
	endsequence

	hiz_input_a: assert property (i_mode == lane_cfg_pkg::MODE_HIZ |=> !o_term_50_q)
		else $error("termination applied in high impedance mode");
	fixed_term_a: assert property ((i_mode == lane_cfg_pkg::MODE_FIXED) [*2] |=> o_term_50_q)
		else $error("fixed termination missing");
	probe_period_a: assert property (probe_due |=> o_probe_q ##1 !o_probe_q)
		else $error("probe not issued at end of period");
	probe_limit_a: assert property (i_mode == lane_cfg_pkg::MODE_LIMITED |-> pcount_q <= ATTEMPTS)
		else $error("too many probes in limited mode");
	detect_term_a: assert property (probe_hit |=> o_term_50_q && !o_probe_q)
		else $error("load found but no termination");
	no_term_wait_a: assert property (o_probe_q && !i_load_seen |=> !o_term_50_q)
		else $error("termination before detection");
endmodule

// File: design/repeater_lane_config_regs.sv
// lane configuration register slice with rx-detect sequencing
`timescale 1ns/100ps
module repeater_lane_config_regs #(
	parameter int PROBE_PERIOD_CYC = lane_cfg_pkg::PROBE_PERIOD_CYC,
	parameter int MAX_ATTEMPTS     = lane_cfg_pkg::MAX_ATTEMPTS
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_wr_en,
	input  wire logic       i_rd_en,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wr_data,
	input  wire logic       i_ee_wr_en,
	input  wire logic [7:0] i_ee_addr,
	input  wire logic [7:0] i_ee_data,
	input  wire logic       i_rx_detect_override,
	input  wire logic [1:0] i_rx_detect_strap,
	input  wire logic       i_threshold_override,
	input  wire logic [3:0] i_threshold_strap,
	input  wire logic       i_load_seen,
	output logic [7:0]      o_rd_data_q,
	output logic [6:0]      o_sd_assert_mv_q,
	output logic [6:0]      o_sd_deassert_mv_q,
	output logic [7:0]      o_eq_q,
	output logic            o_short_prot_q,
	output logic [2:0]      o_swing_code_q,
	output logic [6:0]      o_swing_ratio_q,
	output logic            o_probe_q,
	output logic            o_term_50_q
);

	// assert threshold code to millivolts
	function automatic logic [6:0] assert_mv(input logic [1:0] code);
		case (code)
			2'h0: assert_mv = 7'h32;
			2'h1: assert_mv = 7'h28;
			2'h2: assert_mv = 7'h4B;
			default: assert_mv = 7'h3A;
		endcase
	endfunction

	// deassert threshold code to millivolts
	function automatic logic [6:0] deassert_mv(input logic [1:0] code);
		case (code)
			2'h0: deassert_mv = 7'h25;
			2'h1: deassert_mv = 7'h16;
			2'h2: deassert_mv = 7'h37;
			default: deassert_mv = 7'h2D;
		endcase
	endfunction

	// swing code to ratio in hundredths
	function automatic logic [6:0] swing_ratio(input logic [2:0] code);
		case (code)
			3'h0: swing_ratio = 7'h39;
			3'h1: swing_ratio = 7'h41;
			3'h2: swing_ratio = 7'h47;
			3'h3: swing_ratio = 7'h4D;
			3'h4: swing_ratio = 7'h53;
			3'h5: swing_ratio = 7'h5A;
			3'h6: swing_ratio = 7'h64;
			default: swing_ratio = 7'h68;
		endcase
	endfunction

	// register field or strap pin
	function automatic logic [3:0] pick(input logic ovr, input logic [3:0] regv, input logic [3:0] strap);
		pick = ovr ? regv : strap;
	endfunction

	logic [3:0] thresh_q, thresh_d;
	logic [1:0] detect_q, detect_d;
	logic [7:0] eq_d;
	logic [7:0] swing_q, swing_d;
	logic       wr;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;

	// memory load wins over a host write in the same cycle
	always_comb begin
		wr      = i_ee_wr_en || i_wr_en;
		wr_addr = i_ee_wr_en ? i_ee_addr : i_addr;
		wr_data = i_ee_wr_en ? i_ee_data : i_wr_data;
	end

	// register storage
	always_comb begin
		thresh_d = thresh_q;
		detect_d = detect_q;
		eq_d    = o_eq_q;
		swing_d = swing_q;
		if (wr) begin
			if (wr_addr == lane_cfg_pkg::OFF_THRESH) begin
				thresh_d = wr_data[3:0];
			end else if (wr_addr == lane_cfg_pkg::OFF_DETECT) begin
				detect_d = wr_data[lane_cfg_pkg::DETECT_LSB +: 2];
			end else if (wr_addr == lane_cfg_pkg::OFF_EQ) begin
				eq_d = wr_data;
			end else if (wr_addr == lane_cfg_pkg::OFF_SWING) begin
				swing_d = wr_data;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			thresh_q <= lane_cfg_pkg::RST_THRESH;
			detect_q <= lane_cfg_pkg::RST_DETECT;
			o_eq_q  <= lane_cfg_pkg::RST_EQ;
			swing_q <= lane_cfg_pkg::RST_SWING;
		end else begin
			thresh_q <= thresh_d;
			detect_q <= detect_d;
			o_eq_q  <= eq_d;
			swing_q <= swing_d;
		end
	end

	// readback
	logic [7:0] rd_d;
	always_comb begin
		rd_d = o_rd_data_q;
		if (i_rd_en) begin
			if (i_addr == lane_cfg_pkg::OFF_THRESH) begin
				rd_d = {4'h0, thresh_q};
			end else if (i_addr == lane_cfg_pkg::OFF_DETECT) begin
				rd_d = {4'h0, detect_q, 2'h0};
			end else if (i_addr == lane_cfg_pkg::OFF_EQ) begin
				rd_d = o_eq_q;
			end else if (i_addr == lane_cfg_pkg::OFF_SWING) begin
				rd_d = swing_q;
			end else begin
				rd_d = lane_cfg_pkg::RD_ZERO;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rd_data_q <= lane_cfg_pkg::RD_ZERO;
		end else begin
			o_rd_data_q <= rd_d;
		end
	end

	// effective settings driven to the lane
	logic [1:0] mode_q, mode_d;
	logic [3:0] sd_sel;
	logic [3:0] mode_pick;
	logic [6:0] as_mv_d, de_mv_d, ratio_d;
	logic       scp_d;
	logic [2:0] code_d;

	always_comb begin
		mode_pick = pick(i_rx_detect_override, {2'h0, detect_q}, {2'h0, i_rx_detect_strap});
		mode_d    = mode_pick[1:0];
		sd_sel    = pick(i_threshold_override, thresh_q, i_threshold_strap);
		as_mv_d = assert_mv(sd_sel[lane_cfg_pkg::SD_AS_LSB +: 2]);
		de_mv_d = deassert_mv(sd_sel[lane_cfg_pkg::SD_DE_LSB +: 2]);
		scp_d   = swing_q[lane_cfg_pkg::SCP_BIT];
		code_d  = swing_q[lane_cfg_pkg::SWING_LSB +: 3];
		ratio_d = swing_ratio(code_d);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mode_q             <= lane_cfg_pkg::MODE_HIZ;
			o_sd_assert_mv_q   <= assert_mv(lane_cfg_pkg::RST_THRESH[lane_cfg_pkg::SD_AS_LSB +: 2]);
			o_sd_deassert_mv_q <= deassert_mv(lane_cfg_pkg::RST_THRESH[lane_cfg_pkg::SD_DE_LSB +: 2]);
			o_short_prot_q     <= lane_cfg_pkg::RST_SWING[7];
			o_swing_code_q     <= lane_cfg_pkg::RST_SWING[2:0];
			o_swing_ratio_q    <= swing_ratio(lane_cfg_pkg::RST_SWING[2:0]);
		end else begin
			mode_q             <= mode_d;
			o_sd_assert_mv_q   <= as_mv_d;
			o_sd_deassert_mv_q <= de_mv_d;
			o_short_prot_q     <= scp_d;
			o_swing_code_q     <= code_d;
			o_swing_ratio_q    <= ratio_d;
		end
	end

	rx_detect_seq #(
		.PERIOD_CYC (PROBE_PERIOD_CYC),
		.ATTEMPTS   (MAX_ATTEMPTS),
		.CNT_W      (20)
	) u_rx_detect (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_mode      (mode_q),
		.i_load_seen (i_load_seen),
		.o_probe_q   (o_probe_q),
		.o_term_50_q (o_term_50_q)
	);

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence host_eq_write;
		i_wr_en && !i_ee_wr_en && i_addr == lane_cfg_pkg::OFF_EQ;
	endsequence
	sequence ee_swing_write;
		i_ee_wr_en && i_ee_addr == lane_cfg_pkg::OFF_SWING;
	endsequence

	mode_select_a: assert property (
		##1 mode_q == ($past(i_rx_detect_override) ? $past(detect_q) : $past(i_rx_detect_strap)))
		else $error("rx-detect mode not taken from the selected source");
	assert_thr_a: assert property (
		i_threshold_override && !wr ##1 i_threshold_override |=> o_sd_assert_mv_q == assert_mv($past(thresh_q[3:2], 2)))
		else $error("assert threshold wrong");
	deassert_thr_a: assert property (
		i_threshold_override && !wr ##1 i_threshold_override |=> o_sd_deassert_mv_q == deassert_mv($past(thresh_q[1:0], 2)))
		else $error("deassert threshold wrong");
	strap_thr_a: assert property (
		!i_threshold_override |=> o_sd_assert_mv_q == assert_mv($past(i_threshold_strap[3:2])))
		else $error("strap threshold ignored");
	eq_write_a: assert property (host_eq_write |=> o_eq_q == $past(i_wr_data))
		else $error("equalizer write lost");
	short_prot_a: assert property (
		ee_swing_write |=> ##1 o_short_prot_q == $past(i_ee_data[7], 2))
		else $error("short protection bit not applied");
	swing_map_a: assert property (
		ee_swing_write |=> ##1 o_swing_ratio_q == swing_ratio($past(i_ee_data[2:0], 2)))
		else $error("swing ratio mapping wrong");
	ee_then_host_a: assert property (
		i_ee_wr_en && i_ee_addr == lane_cfg_pkg::OFF_EQ ##1 host_eq_write |=> o_eq_q == $past(i_wr_data))
		else $error("host write blocked after memory load");

	// write requests per register, and a memory load that meets a host write on the equalizer
	sequence thresh_write;
		wr && wr_addr == lane_cfg_pkg::OFF_THRESH;
	endsequence
	sequence detect_write;
		wr && wr_addr == lane_cfg_pkg::OFF_DETECT;
	endsequence
	sequence swing_write;
		wr && wr_addr == lane_cfg_pkg::OFF_SWING;
	endsequence
	sequence both_eq_write;
		i_ee_wr_en && i_wr_en && i_ee_addr == lane_cfg_pkg::OFF_EQ;
	endsequence

	thresh_store_a: assert property (thresh_write |=> thresh_q == $past(wr_data[3:0]))
		else $error("threshold write lost");
	detect_store_a: assert property (
		detect_write |=> detect_q == $past(wr_data[lane_cfg_pkg::DETECT_LSB +: 2]))
		else $error("rx-detect write lost");
	eq_hold_a: assert property (!(wr && wr_addr == lane_cfg_pkg::OFF_EQ) |=> $stable(o_eq_q))
		else $error("equalizer changed without a write");
	swing_store_a: assert property (swing_write |=> swing_q == $past(wr_data))
		else $error("swing write lost");
	ee_priority_a: assert property (both_eq_write |=> o_eq_q == $past(i_ee_data))
		else $error("memory load lost against host write");
	swing_code_a: assert property (
		swing_write |=> ##1 o_swing_code_q == $past(wr_data[2:0], 2))
		else $error("swing code not applied");
	host_prot_a: assert property (
		swing_write |=> ##1 o_short_prot_q == $past(wr_data[7], 2))
		else $error("short protection not applied after host write");
	host_ratio_a: assert property (
		swing_write |=> ##1 o_swing_ratio_q == swing_ratio($past(wr_data[2:0], 2)))
		else $error("swing ratio wrong after host write");
	rd_thresh_a: assert property (
		i_rd_en && i_addr == lane_cfg_pkg::OFF_THRESH |=> o_rd_data_q == {4'h0, $past(thresh_q)})
		else $error("threshold readback wrong");
	rd_detect_a: assert property (
		i_rd_en && i_addr == lane_cfg_pkg::OFF_DETECT |=> o_rd_data_q == {4'h0, $past(detect_q), 2'h0})
		else $error("rx-detect readback wrong");
	rd_eq_a: assert property (
		i_rd_en && i_addr == lane_cfg_pkg::OFF_EQ |=> o_rd_data_q == $past(o_eq_q))
		else $error("equalizer readback wrong");
	rd_swing_a: assert property (
		i_rd_en && i_addr == lane_cfg_pkg::OFF_SWING |=> o_rd_data_q == $past(swing_q))
		else $error("swing readback wrong");
	strap_deassert_a: assert property (
		!i_threshold_override |=> o_sd_deassert_mv_q == deassert_mv($past(i_threshold_strap[1:0])))
		else $error("strap deassert threshold ignored");
	mode_strap_a: assert property (!i_rx_detect_override |=> mode_q == $past(i_rx_detect_strap))
		else $error("strap rx-detect mode ignored");
	mode_reg_a: assert property (i_rx_detect_override |=> mode_q == $past(detect_q))
		else $error("register rx-detect mode ignored");
	probe_mode_a: assert property (
		o_probe_q |-> $past(mode_q) == lane_cfg_pkg::MODE_LIMITED || $past(mode_q) == lane_cfg_pkg::MODE_UNLIMITED)
		else $error("probe outside automatic modes");
	probe_pulse_a: assert property (o_probe_q |=> !o_probe_q)
		else $error("probe longer than one cycle");
	fixed_no_probe_a: assert property (
		$past(mode_q) == lane_cfg_pkg::MODE_FIXED && mode_q == lane_cfg_pkg::MODE_FIXED |=> !o_probe_q)
		else $error("probe issued with fixed termination");
endmodule

// File: testbench/ee_config_loader.sv
// configuration memory model that loads lane settings at power-up
`timescale 1ns/100ps
module ee_config_loader (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_start,
	output logic            o_ee_wr_en,
	output logic [7:0]      o_ee_addr,
	output logic [7:0]      o_ee_data,
	output logic            o_done
);
	int idx;
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			idx <= 0;
			o_ee_wr_en <= 1'b0;
			o_ee_addr <= 8'h00;
			o_ee_data <= 8'h00;
			o_done <= 1'b0;
		end else if (i_start && idx < 2) begin
			// image: equalizer then swing with 0101 in bits 6:3
			o_ee_wr_en <= 1'b1;
			o_ee_addr <= (idx == 0) ? 8'h33 : 8'h34;
			o_ee_data <= (idx == 0) ? 8'h11 : 8'hAE;
			idx <= idx + 1;
		end else begin
			o_ee_wr_en <= 1'b0;
			o_ee_addr <= ~o_ee_addr;
			o_ee_data <= ~o_ee_data;
			o_done <= (idx == 2);
		end
	end
endmodule

// File: testbench/repeater_lane_config_regs_bench.sv
// self-checking bench for the lane configuration slice
`timescale 1ns/100ps
module repeater_lane_config_regs_bench;
	logic       clk, rst, wr_en, rd_en, ee_start, ee_wr, ee_done;
	logic [7:0] addr, wdata, ee_addr, ee_data, rdata, eq, d;
	logic       rx_ovr, sd_ovr, load, sprot, probe, term;
	logic [1:0] rx_strap;
	logic [3:0] sd_strap;
	logic [6:0] as_mv, de_mv, ratio;
	logic [2:0] code;
	int         failures, num_checks, c;
	logic [6:0] as_tbl [4] = '{7'h32, 7'h28, 7'h4B, 7'h3A};
	logic [6:0] de_tbl [4] = '{7'h25, 7'h16, 7'h37, 7'h2D};
	logic [6:0] rt_tbl [8] = '{7'h39, 7'h41, 7'h47, 7'h4D, 7'h53, 7'h5A, 7'h64, 7'h68};

	repeater_lane_config_regs #(.PROBE_PERIOD_CYC(8), .MAX_ATTEMPTS(3)) dut (
		.i_clk(clk), .i_rst(rst), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wdata),
		.i_ee_wr_en(ee_wr), .i_ee_addr(ee_addr), .i_ee_data(ee_data), .i_rx_detect_override(rx_ovr),
		.i_rx_detect_strap(rx_strap), .i_threshold_override(sd_ovr), .i_threshold_strap(sd_strap),
		.i_load_seen(load),
		.o_rd_data_q(rdata), .o_sd_assert_mv_q(as_mv), .o_sd_deassert_mv_q(de_mv), .o_eq_q(eq),
		.o_short_prot_q(sprot), .o_swing_code_q(code), .o_swing_ratio_q(ratio), .o_probe_q(probe),
		.o_term_50_q(term));
	ee_config_loader mem (.i_clk(clk), .i_rst(rst), .i_start(ee_start), .o_ee_wr_en(ee_wr),
		.o_ee_addr(ee_addr), .o_ee_data(ee_data), .o_done(ee_done));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr_en <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		check(rdata, exp);
	endtask
	task automatic probes(input int n);
		c = 0;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (probe === 1'b1) c++;
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic t_reset();
		check(as_mv, 8'h32);
		check(de_mv, 8'h25);
		check(eq, 8'h2F);
		check(sprot, 8'h01);
		check(code, 8'h05);
		check(ratio, 8'h5A);
		check(term, 8'h00);
		rd_check(8'h2F, 8'h00);
		rd_check(8'h32, 8'h00);
		rd_check(8'h33, 8'h2F);
		rd_check(8'h34, 8'hAD);
	endtask
	task automatic t_eeprom();
		@(posedge clk);
		ee_start <= 1'b1;
		repeat (10) @(posedge clk);
		#1;
		check(ee_done, 8'h01);
		rd_check(8'h33, 8'h11);
		rd_check(8'h34, 8'hAE);
		check(ratio, 8'h64);
		wr(8'h33, 8'h22);
		check(eq, 8'h22);
		rd_check(8'h33, 8'h22);
	endtask
	task automatic t_threshold();
		@(posedge clk);
		sd_ovr <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			wr(8'h2F, {4'hF, 4'(i)});
			check(as_mv, as_tbl[i / 4]);
			check(de_mv, de_tbl[i % 4]);
			rd_check(8'h2F, {4'h0, 4'(i)});
		end
		@(posedge clk);
		sd_ovr <= 1'b0;
		sd_strap <= 4'h9;
		repeat (3) @(posedge clk);
		#1;
		check(as_mv, 8'h4B);
		check(de_mv, 8'h16);
	endtask
	task automatic t_swing();
		for (int i = 0; i < 8; i++) begin
			d = {1'(i), 4'h5, 3'(i)};
			wr(8'h34, d);
			check(code, 8'(i));
			check(ratio, rt_tbl[i]);
			check(sprot, 8'(i % 2));
			rd_check(8'h34, d);
		end
	endtask
	task automatic t_reserved();
		wr(8'h30, 8'hFF);
		wr(8'h31, 8'hFF);
		wr(8'h40, 8'hFF);
		rd_check(8'h30, 8'h00);
		rd_check(8'h31, 8'h00);
		rd_check(8'h40, 8'h00);
	endtask
	task automatic t_receiver_detect_mode();
		@(posedge clk);
		rx_ovr <= 1'b1;
		rx_strap <= 2'h1;
		wr(8'h32, 8'hF3);
		rd_check(8'h32, 8'h00);
		probes(30);
		check(8'(c), 8'h00);
		check(term, 8'h00);
		wr(8'h32, 8'h0C);
		probes(30);
		check(term, 8'h01);
		check(8'(c), 8'h00);
		wr(8'h32, 8'h04);
		probes(80);
		check(8'(c), 8'h03);
		check(term, 8'h00);
		wr(8'h32, 8'h08);
		probes(80);
		check(8'(c >= 7), 8'h01);
		check(term, 8'h00);
		@(posedge clk);
		load <= 1'b1;
		repeat (20) @(posedge clk);
		#1;
		check(term, 8'h01);
		wr(8'h32, 8'h00);
		@(posedge clk);
		rx_ovr <= 1'b0;
		rx_strap <= 2'h3;
		repeat (6) @(posedge clk);
		#1;
		check(term, 8'h01);
		@(posedge clk);
		rx_strap <= 2'h0;
		repeat (6) @(posedge clk);
		#1;
		check(term, 8'h00);
	endtask

	initial begin
		failures = 0;
		num_checks = 0;
		rst = 1'b1;
		{wr_en, rd_en, ee_start, rx_ovr, sd_ovr, load} = 6'h00;
		addr = 8'h00;
		wdata = 8'h00;
		rx_strap = 2'h0;
		sd_strap = 4'h0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_eeprom();
		t_threshold();
		t_swing();
		t_reserved();
		t_receiver_detect_mode();
		tally_and_finish();
	end
	initial begin
		#400000;
		failures++;
		tally_and_finish();
	end
endmodule
